// ===== tccdm_defs.svh
// Offsets, field positions, reset values and identity of the timer block.
// Assumes a 32-bit AXI4-Lite slave with a 10-bit byte address.
`ifndef TCCDM_DEFS_SVH
`define TCCDM_DEFS_SVH

// Byte addresses of the registers
`define TCCDM_OFF_CTRL 10'h000
`define TCCDM_OFF_COUNT 10'h004
`define TCCDM_OFF_CAPVAL 10'h008
`define TCCDM_OFF_CMPVAL 10'h00c
`define TCCDM_OFF_DMACNT 10'h010
`define TCCDM_OFF_DMAADR 10'h014
`define TCCDM_OFF_STATUS 10'h018
`define TCCDM_OFF_IRQEN 10'h01c
// Mask register index; byte address is four times it
`define TCCDM_IDX_MASK 8'hff
`define TCCDM_OFF_MASK {`TCCDM_IDX_MASK, 2'b00}

// Control fields
`define TCCDM_CTRL_RUN 0
`define TCCDM_CTRL_FALL 1
// Mask register fields
`define TCCDM_MASK_CMP0 3
`define TCCDM_MASK_CAP0 6
// Status and enable fields
`define TCCDM_ST_CAP 0
`define TCCDM_ST_CMP 1
`define TCCDM_ST_EOB 2

// Reset values
`define TCCDM_RST_CTRL 2'h0
`define TCCDM_RST_MASK 8'h00
`define TCCDM_RST_CMPVAL 16'hffff
`define TCCDM_RST_IRQEN 3'h0

// DMA address step per transfer, in bytes of one 16-bit word
`define TCCDM_DMA_STEP 16'h0002
// Requester code of this timer on the end-of-block bus (arbitrary value)
`define TCCDM_OWN_ID 4'h1

// AXI responses
`define TCCDM_RESP_OKAY 2'b00
`define TCCDM_RESP_SLVERR 2'b10

`endif

// ===== tccdm_pkg.sv
// Types shared by the timer core and the timer top.
// Assumes tccdm_defs.svh supplies the numeric constants.
package tccdm_pkg;

  // Capture and compare events of channel 0, one-cycle pulses
  typedef struct packed {
    logic cap;
    logic cmp;
  } tccdm_evt_t;

  // Request to the DMA controller
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] data;
  } tccdm_dma_req_t;

  // Answer of the DMA controller: grant pulse plus read data
  typedef struct packed {
    logic gnt;
    logic [15:0] rdata;
  } tccdm_dma_rsp_t;

  // End-of-block broadcast with the owner's code
  typedef struct packed {
    logic valid;
    logic [3:0] id;
  } tccdm_eob_t;

  // Which event a DMA transfer serves
  typedef enum logic {
    TCCDM_KIND_CAP = 1'b0,
    TCCDM_KIND_CMP = 1'b1
  } tccdm_kind_t;

endpackage : tccdm_pkg

// ===== tccdm_core.sv
// 16-bit counter with one capture latch and one compare output.
// Assumes the capture input is synchronous to aclk.
`timescale 1ns/1ps
`include "tccdm_defs.svh"

module tccdm_core (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic run, // Counter runs while high
  input wire logic fall_edge, // Capture on falling edge when high
  input wire logic cap_in, // External capture event pin
  input wire logic [15:0] cmp_value, // Compare value
  output logic [15:0] count, // Counter value
  output logic [15:0] cap_value, // Last captured count
  output logic cmp_pin, // Compare output pin
  output tccdm_pkg::tccdm_evt_t evt // Event pulses
);
  import tccdm_pkg::*;

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] cap_reg;
  logic cap_prev_reg;
  logic pin_reg;
  tccdm_evt_t evt_reg;
  logic cap_hit;
  logic cmp_hit;

  // Edge and match detection
  assign cap_hit = run & (fall_edge ? (cap_prev_reg & ~cap_in)
                                    : (~cap_prev_reg & cap_in));
  assign cmp_hit = run & (count_reg == cmp_value);
  assign count_next = run ? count_reg + 16'h0001 : count_reg;

  // Counter, capture latch and pin; the pin toggles on every match
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 16'h0000;
      cap_reg <= 16'h0000;
      cap_prev_reg <= 1'b0;
      pin_reg <= 1'b0;
      evt_reg <= '0;
    end else begin
      count_reg <= count_next;
      cap_prev_reg <= cap_in;
      if (cap_hit) begin
        cap_reg <= count_reg;
      end
      if (cmp_hit) begin
        pin_reg <= ~pin_reg;
      end
      evt_reg <= '{cap: cap_hit, cmp: cmp_hit};
    end
  end

  assign count = count_reg;
  assign cap_value = cap_reg;
  assign cmp_pin = pin_reg;
  assign evt = evt_reg;

endmodule : tccdm_core

// ===== tccdm_timer.sv
// Timer channel 0 with capture, compare and DMA hand-off, AXI4-Lite slave.
// Assumes a DMA controller that grants with a one-cycle pulse and
// broadcasts end of block with the owner's code.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tccdm_defs.svh"

module tccdm_timer (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [9:0] s_axi_awaddr, // Write address
  input wire logic [2:0] s_axi_awprot, // Unused protection bits
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [9:0] s_axi_araddr, // Read address
  input wire logic [2:0] s_axi_arprot, // Unused protection bits
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic cap_in, // Capture event pin
  output logic cmp_pin, // Compare output pin
  input wire logic top_irq, // Top-level interrupt pending
  output tccdm_pkg::tccdm_dma_req_t dma_req, // Request to DMA controller
  input wire tccdm_pkg::tccdm_dma_rsp_t dma_rsp, // Grant and read data
  input wire tccdm_pkg::tccdm_eob_t eob, // End-of-block broadcast
  output logic irq // Interrupt, high while an enabled status bit is set
);
  import tccdm_pkg::*;

  // Software registers
  logic [1:0] ctrl_reg;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic [15:0] cmpval_reg;
  logic [15:0] dmacnt_reg;
  logic [15:0] dmaadr_reg;
  logic [2:0] status_reg;
  logic [2:0] status_next;
  logic [2:0] irqen_reg;
  logic irq_reg;

  // Core outputs
  logic [15:0] count;
  logic [15:0] cap_value;
  tccdm_evt_t evt;

  // DMA side state
  logic cap_pend_reg;
  logic cmp_pend_reg;
  tccdm_dma_req_t req_reg;
  tccdm_kind_t kind_reg;
  tccdm_kind_t last_kind_reg;
  logic eob_armed_reg;

  // AXI state
  logic awready_reg;
  logic wready_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic [9:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  tccdm_core u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(ctrl_reg[`TCCDM_CTRL_RUN]),
    .fall_edge(ctrl_reg[`TCCDM_CTRL_FALL]),
    .cap_in(cap_in),
    .cmp_value(cmpval_reg),
    .count(count),
    .cap_value(cap_value),
    .cmp_pin(cmp_pin),
    .evt(evt)
  );

  // Merge a 16-bit field with the two low byte lanes of a write
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction : merge16

  // Write decode; a write happens once both halves are held
  logic wr_go;
  logic wr_ctrl;
  logic wr_cmpval;
  logic wr_dmacnt;
  logic wr_dmaadr;
  logic wr_irqen;
  logic wr_mask;
  logic wr_hit;
  assign wr_go = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign wr_ctrl = wr_go & (waddr_reg == `TCCDM_OFF_CTRL);
  assign wr_cmpval = wr_go & (waddr_reg == `TCCDM_OFF_CMPVAL);
  assign wr_dmacnt = wr_go & (waddr_reg == `TCCDM_OFF_DMACNT);
  assign wr_dmaadr = wr_go & (waddr_reg == `TCCDM_OFF_DMAADR);
  assign wr_irqen = wr_go & (waddr_reg == `TCCDM_OFF_IRQEN);
  assign wr_mask = wr_go & (waddr_reg == `TCCDM_OFF_MASK);
  // Read-only registers accept writes silently
  assign wr_hit = wr_ctrl | wr_cmpval | wr_dmacnt | wr_dmaadr | wr_irqen
                | wr_mask | (waddr_reg == `TCCDM_OFF_COUNT)
                | (waddr_reg == `TCCDM_OFF_CAPVAL)
                | (waddr_reg == `TCCDM_OFF_STATUS);

  // Read decode
  logic rd_go;
  logic rd_status;
  logic rd_hit;
  logic [31:0] rd_mux;
  assign rd_go = s_axi_arvalid & arready_reg;
  assign rd_status = rd_go & (s_axi_araddr == `TCCDM_OFF_STATUS);
  assign rd_hit = (s_axi_araddr == `TCCDM_OFF_CTRL)
                | (s_axi_araddr == `TCCDM_OFF_COUNT)
                | (s_axi_araddr == `TCCDM_OFF_CAPVAL)
                | (s_axi_araddr == `TCCDM_OFF_CMPVAL)
                | (s_axi_araddr == `TCCDM_OFF_DMACNT)
                | (s_axi_araddr == `TCCDM_OFF_DMAADR)
                | (s_axi_araddr == `TCCDM_OFF_STATUS)
                | (s_axi_araddr == `TCCDM_OFF_IRQEN)
                | (s_axi_araddr == `TCCDM_OFF_MASK);
  assign rd_mux =
      (s_axi_araddr == `TCCDM_OFF_CTRL) ? {30'h0, ctrl_reg} :
      (s_axi_araddr == `TCCDM_OFF_COUNT) ? {16'h0, count} :
      (s_axi_araddr == `TCCDM_OFF_CAPVAL) ? {16'h0, cap_value} :
      (s_axi_araddr == `TCCDM_OFF_CMPVAL) ? {16'h0, cmpval_reg} :
      (s_axi_araddr == `TCCDM_OFF_DMACNT) ? {16'h0, dmacnt_reg} :
      (s_axi_araddr == `TCCDM_OFF_DMAADR) ? {16'h0, dmaadr_reg} :
      (s_axi_araddr == `TCCDM_OFF_STATUS) ? {29'h0, status_reg} :
      (s_axi_araddr == `TCCDM_OFF_IRQEN) ? {29'h0, irqen_reg} :
      (s_axi_araddr == `TCCDM_OFF_MASK) ? {24'h0, mask_reg} :
      32'h0000_0000;

  // Event routing by mask bit: each event goes one way, never both
  logic cap_mask;
  logic cmp_mask;
  logic cap_to_dma;
  logic cmp_to_dma;
  logic cap_to_irq;
  logic cmp_to_irq;
  assign cap_mask = mask_reg[`TCCDM_MASK_CAP0];
  assign cmp_mask = mask_reg[`TCCDM_MASK_CMP0];
  assign cap_to_dma = evt.cap & cap_mask;
  assign cmp_to_dma = evt.cmp & cmp_mask;
  assign cap_to_irq = evt.cap & ~cap_mask;
  assign cmp_to_irq = evt.cmp & ~cmp_mask;

  // Grant and end-of-block qualification
  logic gnt_ok;
  logic eob_own;
  logic [15:0] dmacnt_dec;
  logic [15:0] dmaadr_inc;
  assign gnt_ok = dma_rsp.gnt & req_reg.valid;
  assign eob_own = eob.valid & (eob.id == `TCCDM_OWN_ID)
                 & eob_armed_reg;
  assign dmacnt_dec = dmacnt_reg - 16'h0001;
  assign dmaadr_inc = dmaadr_reg + `TCCDM_DMA_STEP;

  // Mask register: end of block clears the bit in use; a software
  // write in the same cycle wins so a handler can re-arm at once
  always_comb begin
    mask_next = mask_reg;
    if (eob_own) begin
      if (last_kind_reg == TCCDM_KIND_CAP) begin
        mask_next[`TCCDM_MASK_CAP0] = 1'b0;
      end else begin
        mask_next[`TCCDM_MASK_CMP0] = 1'b0;
      end
    end
    if (wr_mask && wstrb_reg[0]) begin
      mask_next = wdata_reg[7:0];
    end
  end

  // Sticky status: a read clears the bits it returned, a new set wins
  always_comb begin
    status_next = status_reg;
    if (rd_status) begin
      status_next = 3'h0;
    end
    status_next[`TCCDM_ST_CAP] = status_next[`TCCDM_ST_CAP] | cap_to_irq;
    status_next[`TCCDM_ST_CMP] = status_next[`TCCDM_ST_CMP] | cmp_to_irq;
    status_next[`TCCDM_ST_EOB] = status_next[`TCCDM_ST_EOB] | eob_own;
  end

  // Control and data registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `TCCDM_RST_CTRL;
      mask_reg <= `TCCDM_RST_MASK;
      irqen_reg <= `TCCDM_RST_IRQEN;
      status_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      status_reg <= status_next;
      irq_reg <= |(status_next & irqen_reg);
      if (wr_ctrl && wstrb_reg[0]) begin
        ctrl_reg <= wdata_reg[1:0];
      end
      if (wr_irqen && wstrb_reg[0]) begin
        irqen_reg <= wdata_reg[2:0];
      end
    end
  end

  // Compare value, DMA counter and address; a grant outranks software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmpval_reg <= `TCCDM_RST_CMPVAL;
      dmacnt_reg <= 16'h0000;
      dmaadr_reg <= 16'h0000;
    end else if (gnt_ok) begin
      dmacnt_reg <= dmacnt_dec;
      dmaadr_reg <= dmaadr_inc;
      if (kind_reg == TCCDM_KIND_CMP) begin
        cmpval_reg <= dma_rsp.rdata;
      end
    end else begin
      if (wr_cmpval) begin
        cmpval_reg <= merge16(cmpval_reg, wdata_reg, wstrb_reg);
      end
      if (wr_dmacnt) begin
        dmacnt_reg <= merge16(dmacnt_reg, wdata_reg, wstrb_reg);
      end
      if (wr_dmaadr) begin
        dmaadr_reg <= merge16(dmaadr_reg, wdata_reg, wstrb_reg);
      end
    end
  end

  // Pending DMA work; a new event keeps a pending one, not a second copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_pend_reg <= 1'b0;
      cmp_pend_reg <= 1'b0;
    end else begin
      if (cap_to_dma) begin
        cap_pend_reg <= 1'b1;
      end else if (gnt_ok && kind_reg == TCCDM_KIND_CAP) begin
        cap_pend_reg <= 1'b0;
      end
      if (cmp_to_dma) begin
        cmp_pend_reg <= 1'b1;
      end else if (gnt_ok && kind_reg == TCCDM_KIND_CMP) begin
        cmp_pend_reg <= 1'b0;
      end
    end
  end

  // Request issue: withdrawn while a top-level interrupt is pending
  // and offered again after, held otherwise until granted
  logic issue_ok;
  assign issue_ok = ~req_reg.valid & ~gnt_ok & ~top_irq;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_reg <= '0;
      kind_reg <= TCCDM_KIND_CAP;
      last_kind_reg <= TCCDM_KIND_CAP;
      eob_armed_reg <= 1'b0;
    end else begin
      if (gnt_ok) begin
        req_reg.valid <= 1'b0;
        last_kind_reg <= kind_reg;
        eob_armed_reg <= 1'b1;
      end else if (req_reg.valid && top_irq) begin
        req_reg.valid <= 1'b0;
      end else if (issue_ok && cap_pend_reg) begin
        req_reg <= '{valid: 1'b1, write: 1'b1, addr: dmaadr_reg,
                     data: cap_value};
        kind_reg <= TCCDM_KIND_CAP;
      end else if (issue_ok && cmp_pend_reg) begin
        req_reg <= '{valid: 1'b1, write: 1'b0, addr: dmaadr_reg,
                     data: 16'h0000};
        kind_reg <= TCCDM_KIND_CMP;
      end
      if (eob_own) begin
        eob_armed_reg <= 1'b0;
      end
    end
  end

  // AXI write channels, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      waddr_reg <= 10'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `TCCDM_RESP_OKAY;
    end else begin
      awready_reg <= s_axi_awvalid & ~awready_reg & ~aw_have_reg
                   & ~bvalid_reg;
      wready_reg <= s_axi_wvalid & ~wready_reg & ~w_have_reg
                  & ~bvalid_reg;
      if (s_axi_awvalid && awready_reg) begin
        aw_have_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_reg) begin
        w_have_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `TCCDM_RESP_OKAY : `TCCDM_RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // AXI read channel; data is sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `TCCDM_RESP_OKAY;
    end else begin
      arready_reg <= s_axi_arvalid & ~arready_reg & ~rvalid_reg;
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= rd_hit ? `TCCDM_RESP_OKAY : `TCCDM_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign dma_req = req_reg;
  assign irq = irq_reg;

endmodule : tccdm_timer

// ===== tccdm_checker.sv
// Port checker for the timer channel: bus answers and DMA request rules.
// Assumes it is bound to tccdm_timer and sees only that module's ports.
`timescale 1ns/1ps
module tccdm_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire logic s_axi_awvalid, // Write address valid
  input wire logic s_axi_awready, // Write address ready
  input wire logic s_axi_wvalid, // Write data valid
  input wire logic s_axi_wready, // Write data ready
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic s_axi_arvalid, // Read address valid
  input wire logic s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic top_irq, // Top-level interrupt
  input wire tccdm_pkg::tccdm_dma_req_t dma_req, // DMA request
  input wire tccdm_pkg::tccdm_dma_rsp_t dma_rsp // DMA grant
);
  import tccdm_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Request steps: waiting for the controller, then granted
  sequence req_waiting;
    dma_req.valid && !dma_rsp.gnt && !top_irq;
  endsequence
  sequence req_granted;
    dma_req.valid && dma_rsp.gnt;
  endsequence
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Data may merge while waiting, so only kind and address must hold
  a_req_holds: assert property (req_waiting |=> dma_req.valid &&
    $stable(dma_req.addr) && $stable(dma_req.write)) else $error("req lost");
  a_grant_ends_req: assert property (req_granted |=> !dma_req.valid)
    else $error("req after grant");
  a_irq_outranks: assert property (top_irq ##1 top_irq |-> !dma_req.valid)
    else $error("req during top irq");
  // Both halves are held one cycle before the response is raised
  a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("no write response");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read data");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_aw_one_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
endmodule : tccdm_checker

bind tccdm_timer tccdm_checker u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .top_irq, .dma_req,
  .dma_rsp);

// ===== tccdm_dma_model.sv
// Behavioural DMA controller: delayed grants, read data, end of block.
// Assumes the bench sets delay and block length before traffic starts.
`timescale 1ns/1ps
`include "tccdm_defs.svh"
module tccdm_dma_model (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire tccdm_pkg::tccdm_dma_req_t dma_req, // Request from timer
  input wire logic [7:0] delay, // Wait cycles before a grant
  input wire logic [7:0] blk_len, // Transfers per block
  input wire logic load, // Restart the block count
  input wire logic foreign, // Send an end of block of another owner
  output tccdm_pkg::tccdm_dma_rsp_t dma_rsp, // Grant and read data
  output tccdm_pkg::tccdm_eob_t eob // End-of-block broadcast
);
  import tccdm_pkg::*;
  logic [7:0] wait_cnt;
  logic [7:0] done;
  logic [15:0] mem;
  // Data bus toggles between grants so stale values never look valid
  always_ff @(posedge aclk) begin
    dma_rsp.gnt <= 1'b0;
    dma_rsp.rdata <= ~dma_rsp.rdata;
    eob <= '0;
    if (!aresetn) begin
      dma_rsp <= '0;
      wait_cnt <= '0;
      done <= '0;
      mem <= 16'h1234;
    end else begin
      if (load) done <= '0;
      if (foreign) eob <= '{valid: 1'b1, id: 4'h2};
      if (dma_rsp.gnt && done == blk_len) eob <= '{1'b1, `TCCDM_OWN_ID};
      if (dma_req.valid && !dma_rsp.gnt) begin
        wait_cnt <= wait_cnt + 8'h01;
        if (wait_cnt >= delay) begin
          dma_rsp <= '{gnt: 1'b1, rdata: mem};
          mem <= mem + 16'h0101;
          wait_cnt <= '0;
          done <= done + 8'h01;
        end
      end else begin
        wait_cnt <= '0;
      end
    end
  end
endmodule : tccdm_dma_model

// ===== timer_capture_compare_dma_mask_bench.sv
// Self-checking bench for the timer channel with a DMA controller model.
// Assumes the checker is bound in and the model grants as programmed.
`timescale 1ns/1ps
`include "tccdm_defs.svh"
module timer_capture_compare_dma_mask_bench;
  import tccdm_pkg::*;
  localparam logic [1:0] OK = `TCCDM_RESP_OKAY;
  localparam logic [1:0] ER = `TCCDM_RESP_SLVERR;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = '0;
  logic [9:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic cap_in = 1'b0;
  logic top_irq = 1'b0;
  logic [7:0] delay = 8'h03;
  logic [7:0] blk_len = 8'h01;
  logic load = 1'b0;
  logic foreign = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cmp_pin, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  tccdm_dma_req_t dma_req;
  tccdm_dma_rsp_t dma_rsp;
  tccdm_eob_t eob;
  int n_errors = 0;
  int cmp_count = 0;
  always #4 aclk = ~aclk;
  // Protection bits are ignored and full strobes cover every register
  tccdm_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cap_in, .cmp_pin, .top_irq, .dma_req, .dma_rsp, .eob,
    .irq);
  tccdm_dma_model u_dma (.aclk, .aresetn, .dma_req, .delay, .blk_len,
    .load, .foreign, .dma_rsp, .eob);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rd
  task automatic cap_edge();
    @(posedge aclk);
    cap_in <= 1'b1;
    @(posedge aclk);
    cap_in <= 1'b0;
  endtask : cap_edge
  task automatic t_reset();
    rd(`TCCDM_OFF_CTRL, 32'h0, OK);
    rd(`TCCDM_OFF_CMPVAL, 32'hffff, OK);
    rd(`TCCDM_OFF_MASK, 32'h0, OK);
    rd(`TCCDM_OFF_IRQEN, 32'h0, OK);
    rd(10'h020, 32'h0, ER);
    wr(10'h020, 32'h1, ER);
  endtask : t_reset
  // Compare match loads the next compare value by DMA, then block ends
  task automatic t_compare();
    wr(`TCCDM_OFF_CMPVAL, 32'h40, OK);
    wr(`TCCDM_OFF_DMACNT, 32'h1, OK);
    wr(`TCCDM_OFF_DMAADR, 32'h200, OK);
    wr(`TCCDM_OFF_MASK, 32'h08, OK);
    wr(`TCCDM_OFF_CTRL, 32'h1, OK);
    while (!dma_req.valid) @(posedge aclk);
    chk({31'h0, cmp_pin}, 32'h1);
    chk({15'h0, dma_req.write, dma_req.addr}, 32'h0200);
    while (dma_req.valid) @(posedge aclk);
    tick(4);
    rd(`TCCDM_OFF_CMPVAL, 32'h1234, OK);
    rd(`TCCDM_OFF_DMACNT, 32'h0, OK);
    rd(`TCCDM_OFF_DMAADR, 32'h202, OK);
    rd(`TCCDM_OFF_MASK, 32'h0, OK);
    wr(`TCCDM_OFF_CMPVAL, 32'hffff, OK);
  endtask : t_compare
  // Slow grant, a top-level interrupt in between, foreign end of block
  task automatic t_capture();
    delay <= 8'h14;
    blk_len <= 8'h02;
    load <= 1'b1;
    wr(`TCCDM_OFF_DMACNT, 32'h2, OK);
    wr(`TCCDM_OFF_DMAADR, 32'h100, OK);
    wr(`TCCDM_OFF_MASK, 32'h40, OK);
    load <= 1'b0;
    cap_edge();
    while (!dma_req.valid) @(posedge aclk);
    chk({15'h0, dma_req.write, dma_req.addr}, 32'h10100);
    top_irq <= 1'b1;
    tick(3);
    chk({31'h0, dma_req.valid}, 32'h0);
    top_irq <= 1'b0;
    while (!(dma_req.valid && dma_rsp.gnt)) @(posedge aclk);
    // Foreign end of block while armed by our grant must be ignored
    foreign <= 1'b1;
    tick(1);
    foreign <= 1'b0;
    rd(`TCCDM_OFF_MASK, 32'h40, OK);
    rd(`TCCDM_OFF_DMACNT, 32'h1, OK);
    rd(`TCCDM_OFF_DMAADR, 32'h102, OK);
    cap_edge();
    while (!(dma_req.valid && dma_rsp.gnt)) @(posedge aclk);
    tick(4);
    rd(`TCCDM_OFF_MASK, 32'h0, OK);
    rd(`TCCDM_OFF_DMACNT, 32'h0, OK);
  endtask : t_capture
  // With the mask cleared a falling-edge event interrupts; handler re-arms
  task automatic t_irq();
    wr(`TCCDM_OFF_IRQEN, 32'h1, OK);
    wr(`TCCDM_OFF_CTRL, 32'h3, OK);
    cap_in <= 1'b1;
    tick(6);
    chk({31'h0, irq}, 32'h0);
    cap_in <= 1'b0;
    tick(6);
    chk({31'h0, dma_req.valid}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(`TCCDM_OFF_IRQEN, 32'h0, OK);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd(`TCCDM_OFF_STATUS, 32'h5, OK);
    rd(`TCCDM_OFF_STATUS, 32'h0, OK);
    wr(`TCCDM_OFF_MASK, 32'h40, OK);
    cap_edge();
    while (!dma_req.valid) @(posedge aclk);
    chk({15'h0, dma_req.write, dma_req.addr}, 32'h10104);
    tick(30);
  endtask : t_irq
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_compare();
    t_capture();
    t_irq();
    complete_run();
  end
  // The whole run needs about three hundred and thirty cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    complete_run();
  end
endmodule : timer_capture_compare_dma_mask_bench
